/* rtl/ocdac_params.svh */
`ifndef OCDAC_PARAMS_SVH
`define OCDAC_PARAMS_SVH

// Word layout
`define OCDAC_BIT_CTRL      15
`define OCDAC_BIT_RST_FULL  12
`define OCDAC_WORD_BITS     16
`define OCDAC_DATA_BITS     12
`define OCDAC_CHANNELS      8

// Control-word field positions
`define OCDAC_BIT_SUP_AD    0
`define OCDAC_BIT_SUP_EH    1
`define OCDAC_BIT_BUF_AD    2
`define OCDAC_BIT_BUF_EH    3
`define OCDAC_BIT_GAIN_AD   4
`define OCDAC_BIT_GAIN_EH   5

// Power-on values
`define OCDAC_RST_MODE      2'h1
`define OCDAC_RST_PDMASK    8'h00
`define OCDAC_RST_CFG       2'h0
`define OCDAC_RST_DATA      12'h000

`endif

/* rtl/ocdac_pkg.sv */
`default_nettype none

package ocdac_pkg;

	typedef enum logic [1:0] {
		OCDAC_CMD_REFGAIN = 2'b00,
		OCDAC_CMD_LDMODE  = 2'b01,
		OCDAC_CMD_PWRDN   = 2'b10,
		OCDAC_CMD_RESET   = 2'b11
	} ocdac_cmd_type;

	typedef enum logic [1:0] {
		OCDAC_LD_LOW    = 2'b00,
		OCDAC_LD_HIGH   = 2'b01,
		OCDAC_LD_SINGLE = 2'b10,
		OCDAC_LD_RSVD   = 2'b11
	} ocdac_ldmode_type;

endpackage
`default_nettype wire

/* rtl/ocdac_shift.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ocdac_params.svh"

// Link-side shifter, runs on the serial clock (falling edge). A finished
// word is held and announced by a toggle, since sclk may stop afterwards.
module ocdac_shift
	import ocdac_pkg::*;
(
	input  wire logic        sclk_i,     // Serial clock from host
	input  wire logic        rstn_i,     // Async reset, active low
	input  wire logic        frame_n_i,  // Frame select, active low
	input  wire logic        sdata_i,    // Serial data
	output logic [15:0]      word_o,     // Captured word
	output logic             word_tgl_o  // Toggles per complete word
);

	logic [14:0] shreg;
	logic [4:0]  count;

	// Frame high holds the stage off and clears a partial word
	always_ff @(negedge sclk_i or posedge frame_n_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count <= 5'h00;
			shreg <= 15'h0000;
		end else if (frame_n_i) begin
			count <= 5'h00;                                   // [RULE11] [RULE24]
			shreg <= 15'h0000;
		end else begin
			shreg <= {shreg[13:0], sdata_i};                  // [RULE20]
			if (count != 5'h10)
				count <= count + 5'h01;
		end
	end

	always_ff @(negedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_o     <= 16'h0000;
			word_tgl_o <= 1'b0;
		end else if (!frame_n_i && count == 5'h0f) begin
			word_o     <= {shreg, sdata_i};                   // [RULE24]
			word_tgl_o <= ~word_tgl_o;
		end
	end

endmodule
`default_nettype wire

/* rtl/ocdac_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-flop level synchroniser
module ocdac_sync (
	input  wire logic mclk_i,  // System clock
	input  wire logic rstn_i,  // Async reset, active low
	input  wire logic d_i,     // Asynchronous level, idles high
	output logic      q_o      // Synchronised level
);

	logic meta;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta <= 1'b1;
			q_o  <= 1'b1;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule
`default_nettype wire

/* rtl/ocdac_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ocdac_params.svh"

// Notes on behaviour
// RULE1: Supply-reference bit 0 for A-D, bit 1 E-H
// RULE2: Supply-reference bit overrides buffer select
// RULE3: Supply reference forces unbuffered, unity range
// RULE4: Code 101 selects load mode from bits 1:0
// RULE5: Mode 00 keeps load permanently active
// RULE6: Mode 01 default, converter registers latched
// RULE7: Mode 10 gives one load pulse
// RULE8: Power-down word powers down masked channels
// RULE9: Reset with bit 12 clear zeroes data
// RULE10: Reset with bit 12 set restores everything
// RULE11: Frame low enables input stage, high disables
// RULE12: Load pin low or mode 00 is transparent
// RULE13: Synchronous load right after sixteenth edge
// RULE14: Load pin falling edge copies input registers
// RULE15: Valid word writes addressed input register
// RULE16: Converter loads only after fresh input write
// RULE17: Gain, buffer, supply bits double-buffered too
// RULE18: Host ties load pin or keeps mode default
// RULE19: Byte hosts keep frame low across two bytes
// RULE20: Words arrive most significant bit first
// RULE21: Host data stable at falling clock edge
// RULE22: Bit 15 set marks a control word
// RULE23: Bit 15 clear is channel data write
// RULE24: Sixteen falling edges, early frame rise discards
// RULE25: Power-on zeroes registers, unbuffered unity gain
// RULE26: Mask bits 0-7 map channels A-H, replace
// RULE27: Single update strobes one cycle, then latched
module ocdac_ctrl
	import ocdac_pkg::*;
#(
	parameter int DATA_BITS = `OCDAC_DATA_BITS
) (
	input  wire logic                   mclk_i,         // System clock
	input  wire logic                   rstn_i,         // Async reset, low
	input  wire logic                   sclk_i,         // Serial clock
	input  wire logic                   frame_n_i,      // Frame select, low
	input  wire logic                   sdata_i,        // Serial data
	input  wire logic                   load_converter_n_i, // Load pin, low
	output logic [8*DATA_BITS-1:0]      dac_data_o,     // Converter regs
	output logic [7:0]                  pwr_down_o,     // Per-channel down
	output logic [1:0]                  ref_buf_o,      // Buffered ref per group
	output logic [1:0]                  gain2_o,        // Double range per group
	output logic [1:0]                  ref_sup_o,      // Supply as ref per group
	output logic [1:0]                  load_mode_o     // Current load mode
);

	localparam int NCH = `OCDAC_CHANNELS;

	logic [15:0] word_l;
	logic        tgl_l;
	logic        tgl_m;
	logic        tgl_s;
	logic        tgl_d;
	logic        ldn_s;
	logic        ldn_d;
	logic        word_evt;
	logic        ldpin_fall;
	logic [15:0] word;

	// Capture runs on the host's clock; only a toggle crosses over
	ocdac_shift u_shift (
		.sclk_i     (sclk_i),
		.rstn_i     (rstn_i),
		.frame_n_i  (frame_n_i),
		.sdata_i    (sdata_i),
		.word_o     (word_l),
		.word_tgl_o (tgl_l)
	);

	// The load pin is asynchronous to both clocks
	ocdac_sync u_ldsync (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.d_i    (load_converter_n_i),
		.q_o    (ldn_s)
	);

	// Toggle crossing; the word is stable long before the toggle settles
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tgl_m <= 1'b0;
			tgl_s <= 1'b0;
			tgl_d <= 1'b0;
		end else begin
			tgl_m <= tgl_l;
			tgl_s <= tgl_m;
			tgl_d <= tgl_s;
		end
	end

	// Starts at the pin's idle level, so reset gives no false edge
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			ldn_d <= 1'b1;
		else
			ldn_d <= ldn_s;
	end

	// Copy the word only once the toggle has settled, then decode the copy
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word     <= 16'h0000;
			word_evt <= 1'b0;
		end else begin
			word_evt <= tgl_s ^ tgl_d;
			if (tgl_s ^ tgl_d)
				word <= word_l;
		end
	end

	assign ldpin_fall = ldn_d & ~ldn_s;

	// Decode
	logic       is_ctrl;
	logic       is_data;
	logic       is_rg;
	logic       is_lm;
	logic       is_pd;
	logic       is_rst;
	logic       rst_full;
	logic [2:0] addr;
	assign is_ctrl  = word_evt & word[`OCDAC_BIT_CTRL];             // [RULE22]
	assign is_data  = word_evt & ~word[`OCDAC_BIT_CTRL];            // [RULE23]
	assign addr     = word[14:12];
	assign is_rg    = is_ctrl & (word[14:13] == OCDAC_CMD_REFGAIN);
	assign is_lm    = is_ctrl & (word[14:13] == OCDAC_CMD_LDMODE);  // [RULE4]
	assign is_pd    = is_ctrl & (word[14:13] == OCDAC_CMD_PWRDN);
	assign is_rst   = is_ctrl & (word[14:13] == OCDAC_CMD_RESET);
	assign rst_full = is_rst & word[`OCDAC_BIT_RST_FULL];           // [RULE10]

	// Load mode and single-update strobe
	ocdac_ldmode_type mode;
	logic             single;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode <= ocdac_ldmode_type'(`OCDAC_RST_MODE);         // [RULE6]
		end else if (rst_full) begin
			mode <= ocdac_ldmode_type'(`OCDAC_RST_MODE);         // [RULE10]
		end else if (is_lm) begin
			unique case (ocdac_ldmode_type'(word[1:0]))
				OCDAC_LD_LOW:    mode <= OCDAC_LD_LOW;          // [RULE5]
				OCDAC_LD_HIGH:   mode <= OCDAC_LD_HIGH;         // [RULE6]
				OCDAC_LD_SINGLE: mode <= OCDAC_LD_HIGH;         // [RULE27]
				OCDAC_LD_RSVD:   mode <= mode;                  // [RULE4]
			endcase
		end
	end

	// Cleared on every edge without a single-update word: one cycle wide
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			single <= 1'b0;
		else
			single <= is_lm && (word[1:0] == OCDAC_LD_SINGLE); // [RULE7]
	end

	// Load is active for transparent cases, the one-cycle strobe, or pin edge
	logic load;
	assign load = (mode == OCDAC_LD_LOW) | ~ldn_s | single | ldpin_fall; // [RULE12] [RULE14]

	// Power-down mask
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			pwr_down_o <= `OCDAC_RST_PDMASK;
		else if (rst_full)
			pwr_down_o <= `OCDAC_RST_PDMASK;                       // [RULE10]
		else if (is_pd)
			pwr_down_o <= word[7:0];                               // [RULE8] [RULE26]
	end

	// Config: input copy and active copy, per group
	logic [1:0] in_sup;
	logic [1:0] in_buf;
	logic [1:0] in_gain;
	logic       cfg_fresh;
	logic [1:0] act_sup;
	logic [1:0] act_buf;
	logic [1:0] act_gain;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			in_sup  <= `OCDAC_RST_CFG;                             // [RULE25]
			in_buf  <= `OCDAC_RST_CFG;
			in_gain <= `OCDAC_RST_CFG;
		end else if (rst_full) begin
			in_sup  <= `OCDAC_RST_CFG;
			in_buf  <= `OCDAC_RST_CFG;
			in_gain <= `OCDAC_RST_CFG;
		end else if (is_rg) begin
			in_sup  <= {word[`OCDAC_BIT_SUP_EH], word[`OCDAC_BIT_SUP_AD]}; // [RULE1]
			in_buf  <= {word[`OCDAC_BIT_BUF_EH], word[`OCDAC_BIT_BUF_AD]};
			in_gain <= {word[`OCDAC_BIT_GAIN_EH], word[`OCDAC_BIT_GAIN_AD]};
		end
	end

	// Set wins over the load clear so a write in the load cycle is kept
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			cfg_fresh <= 1'b0;
		else if (rst_full)
			cfg_fresh <= 1'b0;
		else if (is_rg)
			cfg_fresh <= 1'b1;
		else if (load)
			cfg_fresh <= 1'b0;                                     // [RULE16]
	end

	// Active copy changes only through the load path or a full reset
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_sup  <= `OCDAC_RST_CFG;
			act_buf  <= `OCDAC_RST_CFG;
			act_gain <= `OCDAC_RST_CFG;
		end else if (rst_full) begin
			act_sup  <= `OCDAC_RST_CFG;
			act_buf  <= `OCDAC_RST_CFG;
			act_gain <= `OCDAC_RST_CFG;
		end else if (!is_rg && load && cfg_fresh) begin
			act_sup  <= in_sup;                                    // [RULE17]
			act_buf  <= in_buf;
			act_gain <= in_gain;
		end
	end

	// Supply reference overrides buffer and gain
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_sup_o <= `OCDAC_RST_CFG;
			ref_buf_o <= `OCDAC_RST_CFG;
			gain2_o   <= `OCDAC_RST_CFG;
		end else begin
			ref_sup_o <= act_sup;
			ref_buf_o <= act_buf & ~act_sup;                       // [RULE2] [RULE3]
			gain2_o   <= act_gain & ~act_sup;                      // [RULE3]
		end
	end

	// Reported mode follows the internal one a cycle later
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			load_mode_o <= `OCDAC_RST_MODE;
		else
			load_mode_o <= mode;
	end

	// Per-channel input and converter registers
	logic [DATA_BITS-1:0] in_reg [NCH];
	logic [NCH-1:0]       fresh;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic wr;
			assign wr = is_data && (addr == 3'(ch));

			// Either reset word clears data; only the full one touches config
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i)
					in_reg[ch] <= DATA_BITS'(0);                       // [RULE25]
				else if (is_rst)
					in_reg[ch] <= DATA_BITS'(0);                       // [RULE9]
				else if (wr)
					in_reg[ch] <= word[11 -: DATA_BITS];               // [RULE15]
			end

			// A write in a load cycle keeps the flag and loads a cycle later
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i)
					fresh[ch] <= 1'b0;
				else if (is_rst)
					fresh[ch] <= 1'b0;
				else if (wr)
					fresh[ch] <= 1'b1;                                 // [RULE13]
				else if (load)
					fresh[ch] <= 1'b0;                                 // [RULE16]
			end

			// Converter register takes only a fresh input register
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i)
					dac_data_o[ch*DATA_BITS +: DATA_BITS] <= DATA_BITS'(0);
				else if (is_rst)
					dac_data_o[ch*DATA_BITS +: DATA_BITS] <= DATA_BITS'(0); // [RULE9]
				else if (!wr && load && fresh[ch])
					dac_data_o[ch*DATA_BITS +: DATA_BITS] <= in_reg[ch]; // [RULE12]
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* verif/ocdac_checker.sv */
`timescale 1ns/10ps
`default_nettype none

module ocdac_checker #(
	parameter int DATA_BITS = 12
) (
	input wire logic                 mclk_i,             // System clock
	input wire logic                 rstn_i,             // Reset, low
	input wire logic                 frame_n_i,          // Frame select
	input wire logic                 load_converter_n_i, // Load pin
	input wire logic [8*DATA_BITS-1:0] dac_data_o,       // Converter regs
	input wire logic [7:0]           pwr_down_o,         // Power-down mask
	input wire logic [1:0]           ref_buf_o,          // Buffered ref
	input wire logic [1:0]           gain2_o,            // Double range
	input wire logic [1:0]           ref_sup_o,          // Supply ref
	input wire logic [1:0]           load_mode_o         // Load mode
);
	// Idle cycles with no frame and no load pin; saturates
	logic [3:0] quiet;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			quiet <= 4'h0;
		else if (!frame_n_i || !load_converter_n_i)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	reset_state_a: assert property ($rose(rstn_i) |-> load_mode_o == 2'h1
		&& pwr_down_o == 8'h00 && dac_data_o == '0)
		else $error("outputs not at power-on values");
	mode_legal_a: assert property (load_mode_o inside {2'h0, 2'h1})
		else $error("load mode left its legal values");
	sup_low_a: assert property (ref_sup_o[0] |-> !ref_buf_o[0] && !gain2_o[0])
		else $error("group A-D supply reference not overriding");
	sup_high_a: assert property (ref_sup_o[1] |-> !ref_buf_o[1] && !gain2_o[1])
		else $error("group E-H supply reference not overriding");
	dac_hold_a: assert property (quiet > 4'h9 |-> $stable(dac_data_o))
		else $error("converter data moved while idle");
	cfg_hold_a: assert property (quiet > 4'h9 |-> $stable({ref_buf_o, gain2_o, ref_sup_o}))
		else $error("reference settings moved while idle");
	mask_hold_a: assert property (frame_n_i [*8] |=> $stable(pwr_down_o))
		else $error("power-down mask moved without a word");
	mode_hold_a: assert property (frame_n_i [*8] |=> $stable(load_mode_o))
		else $error("load mode moved without a word");
endmodule

bind ocdac_ctrl ocdac_checker #(.DATA_BITS(DATA_BITS)) u_chk (.mclk_i, .rstn_i,
	.frame_n_i, .load_converter_n_i, .dac_data_o, .pwr_down_o, .ref_buf_o,
	.gain2_o, .ref_sup_o, .load_mode_o);

`default_nettype wire

/* verif/ocdac_host.sv */
`timescale 1ns/10ps
`default_nettype none

module ocdac_host (
	output logic sclk_o,    // Serial clock, still outside frames
	output logic frame_n_o, // Frame select
	output logic sdata_o    // Serial data
);
	initial begin
		sclk_o = 1'b0;
		frame_n_o = 1'b1;
		sdata_o = 1'b0;
	end

	// Data moves on the rising edge so it is settled at the falling one
	task automatic xfer(input logic [15:0] w, input int n, input bit split);
		#37 frame_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			#30 sclk_o = 1'b1;
			sdata_o = w[i];
			#62.5 sclk_o = 1'b0;
			#32.5;
			if (split && i == 8)
				#400;
		end
		#50 frame_n_o = 1'b1;
		sdata_o = ~sdata_o;
	endtask
endmodule

`default_nettype wire

/* verif/octal_dac_control_double_buffer_test.sv */
`timescale 1ns/10ps
`default_nettype none

module octal_dac_control_double_buffer_test;
	logic        mclk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        ld_pin_n = 1'b1; // Software updates keep the pin high
	wire         sclk, frame_n, sdata;
	logic [95:0] dac;
	logic [7:0]  pd_o;
	logic [1:0]  buf_o, gain_o, sup_o, mode_o;
	int          n_fail = 0;
	int          total_checks = 0;
	int          ir[8], dr[8], md = 1, ci = 0, co = 0, pd = 0;
	bit          fr[8], cf;

	always #20 mclk_i = ~mclk_i;

	ocdac_host u_host (.sclk_o(sclk), .frame_n_o(frame_n), .sdata_o(sdata));
	ocdac_ctrl DUT (.mclk_i, .rstn_i, .sclk_i(sclk), .frame_n_i(frame_n),
		.sdata_i(sdata), .load_converter_n_i(ld_pin_n), .dac_data_o(dac),
		.pwr_down_o(pd_o), .ref_buf_o(buf_o), .gain2_o(gain_o),
		.ref_sup_o(sup_o), .load_mode_o(mode_o));

	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic load_fresh;
		for (int i = 0; i < 8; i++)
			if (fr[i]) begin
				dr[i] = ir[i];
				fr[i] = 0;
			end
		if (cf)
			co = ci;
		cf = 0;
	endtask

	task automatic check_all;
		logic [95:0] e;
		for (int i = 0; i < 8; i++)
			e[i*12+:12] = 12'(dr[i]);
		chk(dac, e);
		chk(96'(pd_o), 96'(pd));
		chk(96'(mode_o), 96'(md));
		chk(96'(sup_o), 96'(co & 3));
		chk(96'(buf_o), 96'((co >> 2) & ~co & 3));
		chk(96'(gain_o), 96'((co >> 4) & ~co & 3));
	endtask

	task automatic send(input logic [15:0] w, input int n = 16, input bit sp = 0);
		u_host.xfer(w, n, sp);
		repeat (12) @(posedge mclk_i);
		#1;
		if (n == 16) begin
			if (!w[15]) begin
				ir[w[14:12]] = w[11:0];
				fr[w[14:12]] = 1;
			end else case (w[14:13])
				2'h0: begin
					ci = w[5:0];
					cf = 1;
				end
				2'h1: if (w[1:0] != 2'h3)
					md = w[1:0];
				2'h2: pd = w[7:0];
				2'h3: begin
					ir = '{default: 0};
					dr = ir;
					fr = '{default: 0};
					if (w[12]) begin
						ci = 0;
						co = 0;
						cf = 0;
						md = 1;
						pd = 0;
					end
				end
			endcase
			if (md != 1)
				load_fresh();
			if (md == 2)
				md = 1;
		end
		check_all();
	endtask

	task automatic pulse_pin;
		ld_pin_n = 1'b0;
		repeat (6) @(posedge mclk_i);
		#1 ld_pin_n = 1'b1;
		load_fresh();
		repeat (12) @(posedge mclk_i);
		#1 check_all();
	endtask

	task automatic give_verdict;
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		void'($urandom(87292));
		repeat (12) @(posedge mclk_i);
		#1 rstn_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#1 check_all();
		for (int i = 0; i < 8; i++)
			send({1'b0, 3'(i), 12'($urandom)});
		send(16'h8000 | 16'($urandom & 'h3f));
		pulse_pin();
		send(16'h803e);
		send(16'hbfff);
		send(16'ha002);
		send({4'h0, 12'($urandom)}, 9);
		send(16'hbffc);
		for (int i = 0; i < 8; i++)
			send({1'b0, 3'(i), 12'($urandom)}, 16, i[0]);
		send(16'ha001);
		send(16'h5abc);
		send(16'hc000 | 16'($urandom & 'hff));
		send(16'he000);
		send(16'h8015);
		pulse_pin();
		send(16'hf000);
		give_verdict();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk_i);
		n_fail++;
		give_verdict();
	end
endmodule

`default_nettype wire
